// File: design/pci_phase_consts.vh
// Constants for the PCI target bus-phase front end
// Function
// - Memory read multiple, read line and write-and-invalidate run as plain memory read or write.
// - Parity is even over the 32 address/data lines and the four command/byte-enable lines.
// - Read-data parity is driven by the target one clock after target-ready.
// - All bus signals are sampled and driven on the rising PCI clock edge.
// - The logic works at PCI clock rates down to a stopped clock and keeps its state; each PCI clock phase must span a clk_in cycle.
// - A data phase completes only when both ready signals are asserted.
// - The target asserts target-ready only when it can complete, with read data valid.
// - The target asserts device-select after decoding an address and command of its own.
`ifndef PCI_PHASE_CONSTS_VH
`define PCI_PHASE_CONSTS_VH
`define CMD_MEM_RD     4'h6
`define CMD_MEM_WR     4'h7
`define CMD_CFG_RD     4'hA
`define CMD_CFG_WR     4'hB
`define CMD_MEM_RD_MUL 4'hC
`define CMD_MEM_RD_LN  4'hE
`define CMD_MEM_WR_INV 4'hF
`define FIFO_DEPTH_DEF 32
`endif

// File: design/pci_phase_fifo.v
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module pci_phase_fifo #(
  parameter WIDTH = 36,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             clk_in,
  input  wire             rst_n_in,
  input  wire [WIDTH-1:0] wr_data_in,
  input  wire             wr_valid_in,
  output wire             wr_ready_out,
  output wire [WIDTH-1:0] rd_data_out,
  output wire             rd_valid_out,
  input  wire             rd_ready_in
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW:0]      wp_q;
  reg [AW:0]      rp_q;
  wire            push;
  wire            pop;
  // Full when pointers differ by the depth
  assign wr_ready_out = ((wp_q - rp_q) != DEPTH[AW:0]);
  assign rd_valid_out = (wp_q != rp_q);
  assign push = wr_valid_in & wr_ready_out;
  assign pop  = rd_valid_out & rd_ready_in;
  assign rd_data_out = mem_q[rp_q[AW-1:0]];
  // Storage write, no reset needed
  always @(posedge clk_in) begin
    if (push) begin
      mem_q[wp_q[AW-1:0]] <= wr_data_in;
    end
  end
  // Pointers
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      wp_q <= {(AW+1){1'b0}};
      rp_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: design/pci_target_bus_phase_logic.v
// PCI target bus-phase front end: decode, parity, phase tracking
`timescale 1ns/10ps
`default_nettype none
`include "pci_phase_consts.vh"
module pci_target_bus_phase_logic #(
  parameter DEPTH = `FIFO_DEPTH_DEF,
  parameter AW    = 5
) (
  input  wire        clk_in,
  input  wire        rst_n_in,
  input  wire        pci_clk_in,
  input  wire        frame_n_in,
  input  wire        irdy_n_in,
  input  wire [31:0] ad_in,
  input  wire [3:0]  cbe_n_in,
  input  wire        par_in,
  output reg         par_out,
  output reg         par_oe_n_out,
  output reg         ad_oe_n_out,
  output reg [31:0]  ad_out,
  output reg         trdy_n_out,
  output reg         devsel_n_out,
  input  wire        hit_in,
  input  wire        idsel_in,
  output reg         addr_perr_out,
  output reg         data_perr_out,
  output reg         is_write_out,
  output reg         is_cfg_out,
  output reg [31:0]  addr_out,
  output reg         addr_valid_out,
  output reg         final_phase_out,
  output reg         wait_state_out,
  output wire [35:0] wdata_out,
  output wire        wdata_valid_out,
  input  wire        wdata_ready_in,
  input  wire [31:0] rdata_in,
  input  wire        rdata_valid_in,
  output wire        rdata_ready_out
);
  localparam ST_IDLE = 4'h1;
  localparam ST_ADDR = 4'h2;
  localparam ST_DATA = 4'h4;
  localparam ST_DONE = 4'h8;
  // Two-stage sync of every pin; first stage feeds only second
  reg        clk_s1_q, clk_s2_q, clk_s3_q;
  reg        frm_s1_q, frm_s2_q, irdy_s1_q, irdy_s2_q, par_s1_q, par_s2_q;
  reg [31:0] ad_s1_q, ad_s2_q;
  reg [3:0]  cbe_s1_q, cbe_s2_q;
  reg        hit_s1_q, hit_s2_q, ids_s1_q, ids_s2_q;
  reg [3:0]  st_q;
  reg        chk_addr_q, chk_data_q, par_drv_q, rd_pend_q;
  reg [35:0] pword_q;
  reg [35:0] bus_prev_q;
  reg        fifo_wr_q;
  wire       fifo_ready;
  wire       edge_rise;
  wire [3:0] cmd;
  wire       cmd_rd, cmd_wr, cmd_cfg, cmd_ok, claim;
  wire       xfer;
  // PCI clock sampled as data; bench period is 8 system clocks
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      clk_s1_q <= 1'b0; clk_s2_q <= 1'b0; clk_s3_q <= 1'b0;
      frm_s1_q <= 1'b1; frm_s2_q <= 1'b1;
      irdy_s1_q <= 1'b1; irdy_s2_q <= 1'b1;
      par_s1_q <= 1'b0; par_s2_q <= 1'b0;
      ad_s1_q <= 32'h0; ad_s2_q <= 32'h0;
      cbe_s1_q <= 4'hF; cbe_s2_q <= 4'hF;
      hit_s1_q <= 1'b0; hit_s2_q <= 1'b0;
      ids_s1_q <= 1'b0; ids_s2_q <= 1'b0;
    end else begin
      clk_s1_q <= pci_clk_in; clk_s2_q <= clk_s1_q; clk_s3_q <= clk_s2_q;
      frm_s1_q <= frame_n_in; frm_s2_q <= frm_s1_q;
      irdy_s1_q <= irdy_n_in; irdy_s2_q <= irdy_s1_q;
      par_s1_q <= par_in; par_s2_q <= par_s1_q;
      ad_s1_q <= ad_in; ad_s2_q <= ad_s1_q;
      cbe_s1_q <= cbe_n_in; cbe_s2_q <= cbe_s1_q;
      hit_s1_q <= hit_in; hit_s2_q <= hit_s1_q;
      ids_s1_q <= idsel_in; ids_s2_q <= ids_s1_q;
    end
  end
  // no edge, no change: stopped clock holds all bus-side state; write FIFO still drains
  assign edge_rise = clk_s2_q & ~clk_s3_q;
  // aliases fold onto basic read and write
  assign cmd     = cbe_s2_q;
  assign cmd_rd  = (cmd == `CMD_MEM_RD) | (cmd == `CMD_MEM_RD_MUL) |
                   (cmd == `CMD_MEM_RD_LN) | (cmd == `CMD_CFG_RD);
  assign cmd_wr  = (cmd == `CMD_MEM_WR) | (cmd == `CMD_MEM_WR_INV) |
                   (cmd == `CMD_CFG_WR);
  assign cmd_cfg = (cmd == `CMD_CFG_RD) | (cmd == `CMD_CFG_WR);
  assign cmd_ok  = cmd_rd | cmd_wr;
  assign claim   = cmd_ok & (cmd_cfg ? ids_s2_q : hit_s2_q);
  // phase completes only with both readies
  assign xfer    = ~irdy_s2_q & ~trdy_n_out;
  // Pulses only when a word is really taken into ad_out
  assign rdata_ready_out = (st_q == ST_DATA) & ~is_write_out &
                           trdy_n_out & edge_rise & rdata_valid_in;
  // Phase tracker and target outputs
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_q <= ST_IDLE;
      trdy_n_out <= 1'b1; devsel_n_out <= 1'b1;
      ad_oe_n_out <= 1'b1; ad_out <= 32'h0;
      par_out <= 1'b0; par_oe_n_out <= 1'b1;
      addr_out <= 32'h0; addr_valid_out <= 1'b0;
      is_write_out <= 1'b0; is_cfg_out <= 1'b0;
      final_phase_out <= 1'b0; wait_state_out <= 1'b0;
      addr_perr_out <= 1'b0; data_perr_out <= 1'b0;
      chk_addr_q <= 1'b0; chk_data_q <= 1'b0;
      par_drv_q <= 1'b0; rd_pend_q <= 1'b0;
      pword_q <= 36'h0; fifo_wr_q <= 1'b0;
      bus_prev_q <= 36'h0;
    end else begin
      addr_valid_out <= 1'b0;
      fifo_wr_q <= 1'b0;
      if (edge_rise) begin
        // Parity trails its phase, so keep last clock's bus word
        bus_prev_q <= {cbe_s2_q, ad_s2_q};
        // address parity checked one clock later
        if (chk_addr_q) begin
          addr_perr_out <= ^{bus_prev_q, par_s2_q};
        end
        // write parity one clock after the phase
        if (chk_data_q) begin
          data_perr_out <= ^{bus_prev_q, par_s2_q};
        end
        chk_addr_q <= 1'b0;
        chk_data_q <= 1'b0;
        // read parity one clock after target-ready
        // even over data and byte enables
        par_drv_q <= 1'b0;
        if (!trdy_n_out && !is_write_out && xfer) begin
          par_out <= ^{ad_out, cbe_s2_q};
          par_oe_n_out <= 1'b0;
          par_drv_q <= 1'b1;
        end else if (par_drv_q) begin
          par_oe_n_out <= 1'b1;
        end
        wait_state_out <= (st_q == ST_DATA) & ~xfer;
        case (st_q)
          ST_IDLE: begin
            // frame start carries address and command
            if (!frm_s2_q) begin
              chk_addr_q <= 1'b1;
              addr_out <= ad_s2_q;
              is_write_out <= cmd_wr;
              is_cfg_out <= cmd_cfg;
              if (claim) begin
                addr_valid_out <= 1'b1;
                st_q <= ST_ADDR;
              end else begin
                st_q <= ST_DONE;
              end
            end
          end
          ST_ADDR: begin
            devsel_n_out <= 1'b0;
            ad_oe_n_out <= is_write_out;
            final_phase_out <= frm_s2_q;
            trdy_n_out <= ~is_write_out | ~fifo_ready;
            st_q <= ST_DATA;
          end
          ST_DATA: begin
            final_phase_out <= frm_s2_q;
            if (xfer) begin
              if (is_write_out) begin
                pword_q <= {cbe_s2_q, ad_s2_q};
                fifo_wr_q <= 1'b1;
                chk_data_q <= 1'b1;
              end
              // Held word is spent; a stale flag would replay it
              rd_pend_q <= 1'b0;
              if (frm_s2_q) begin
                trdy_n_out <= 1'b1;
                devsel_n_out <= 1'b1;
                ad_oe_n_out <= 1'b1;
                st_q <= ST_IDLE;
              end else begin
                trdy_n_out <= 1'b1;
                rd_pend_q <= 1'b0;
              end
            end else if (trdy_n_out) begin
              // ready only when data or room exists
              if (is_write_out) begin
                trdy_n_out <= ~fifo_ready;
              end else if (rdata_valid_in || rd_pend_q) begin
                if (!rd_pend_q) begin
                  ad_out <= rdata_in;
                end
                rd_pend_q <= 1'b1;
                trdy_n_out <= 1'b0;
              end
            end
          end
          ST_DONE: begin
            if (frm_s2_q && irdy_s2_q) begin
              st_q <= ST_IDLE;
            end
          end
          default: st_q <= ST_IDLE;
        endcase
      end
    end
  end
  // Write data buffered; full FIFO holds off target-ready
  pci_phase_fifo #(
    .WIDTH (36),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_wfifo (
    .clk_in       (clk_in),
    .rst_n_in     (rst_n_in),
    .wr_data_in   (pword_q),
    .wr_valid_in  (fifo_wr_q),
    .wr_ready_out (fifo_ready),
    .rd_data_out  (wdata_out),
    .rd_valid_out (wdata_valid_out),
    .rd_ready_in  (wdata_ready_in)
  );
endmodule
`default_nettype wire

// File: testbench/pci_phase_assertions.sv
// Port-level checks for the PCI target bus-phase front end
`timescale 1ns/10ps
`default_nettype none
module pci_phase_chk #(
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic        pci_clk_in,
  input wire logic        trdy_n_out,
  input wire logic        devsel_n_out,
  input wire logic        ad_oe_n_out,
  input wire logic        par_oe_n_out,
  input wire logic        is_write_out,
  input wire logic        addr_valid_out,
  input wire logic [35:0] wdata_out,
  input wire logic        wdata_valid_out,
  input wire logic        wdata_ready_in,
  input wire logic        rdata_valid_in,
  input wire logic        rdata_ready_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // No PCI edge left in the synchroniser
  sequence pci_still;
    $stable(pci_clk_in)[*7];
  endsequence
  clock_stop_hold_a: assert property (
    pci_still |=> $stable(devsel_n_out) && $stable(par_oe_n_out))
    else $error("bus outputs moved with PCI clock stopped");
  ready_needs_sel_a: assert property (
    !trdy_n_out |-> !devsel_n_out) else $error("trdy without devsel");
  read_ad_drive_a: assert property (
    !ad_oe_n_out |-> !is_write_out) else $error("AD driven on a write");
  read_par_drive_a: assert property (
    !par_oe_n_out |-> !is_write_out) else $error("PAR driven on a write");
  claim_pulse_a: assert property (
    addr_valid_out |=> !addr_valid_out) else $error("claim pulse too long");
  read_take_a: assert property (
    rdata_ready_out |-> rdata_valid_in ##1 !trdy_n_out)
    else $error("read word taken unoffered or trdy late");
  write_hold_a: assert property (
    wdata_valid_out && !wdata_ready_in |=> wdata_valid_out && $stable(wdata_out))
    else $error("write word dropped while stalled");
  reset_idle_a: assert property (
    $rose(rst_n_in) |-> devsel_n_out && trdy_n_out && par_oe_n_out && ad_oe_n_out)
    else $error("bus not idle after reset");
endmodule
bind pci_target_bus_phase_logic pci_phase_chk #(.DEPTH(DEPTH), .AW(AW)) u_chk (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .pci_clk_in(pci_clk_in),
  .trdy_n_out(trdy_n_out), .devsel_n_out(devsel_n_out),
  .ad_oe_n_out(ad_oe_n_out), .par_oe_n_out(par_oe_n_out),
  .is_write_out(is_write_out), .addr_valid_out(addr_valid_out),
  .wdata_out(wdata_out), .wdata_valid_out(wdata_valid_out),
  .wdata_ready_in(wdata_ready_in), .rdata_valid_in(rdata_valid_in),
  .rdata_ready_out(rdata_ready_out));
`default_nettype wire

// File: testbench/pci_master_model.sv
// Behavioural PCI bus master facing the target front end
`timescale 1ns/10ps
`default_nettype none
module pci_master_model (
  output logic             pci_clk = 1'b0,
  output logic             frame_n = 1'b1,
  output logic             irdy_n = 1'b1,
  output logic             par = 1'b0,
  output logic [31:0]      ad = 32'h0,
  output logic [3:0]       cbe_n = 4'h0,
  input  wire logic        trdy_n,
  input  wire logic        devsel_n,
  input  wire logic        par_oe_n,
  input  wire logic        par_rd,
  input  wire logic [31:0] ad_rd
);
  logic [31:0] wq [0:63];
  logic [31:0] rq [0:63];
  logic [35:0] pv;
  logic [31:0] rp;
  int          bad = 0;
  int          got;
  logic        seen, chk;
  // Clock runs only inside a transfer; idle lines keep toggling
  task automatic xfer(input logic [3:0] cmd, input logic [31:0] a,
                      input int n, input bit rd, input bit bp);
    int t;
    got = 0; t = 0; seen = 0; chk = 0;
    #7;
    frame_n = 1'b0; ad = a; cbe_n = cmd; pv = {cmd, a};
    for (int g = 0; g < 400 && t < 4; g++) begin
      #159 pci_clk = 1'b1;
      if (chk && (par_oe_n !== 1'b0 || par_rd !== ^rp)) bad++;
      chk = 1'b0;
      if (!devsel_n) seen = 1'b1;
      if (!irdy_n && !trdy_n && got < n) begin
        rq[got] = ad_rd; rp = ad_rd; chk = rd; got++;
      end
      // Bus moves at the falling edge, clear of the sampled rise
      #160 pci_clk = 1'b0;
      par = (rd && g > 0) ? ~par : ^pv ^ (bp && g > 0);
      if (got >= n || (devsel_n && g > 5)) begin
        frame_n = 1'b1; irdy_n = 1'b1; ad = ~ad; t++;
      end else begin
        irdy_n = 1'b0; frame_n = (got == n - 1); cbe_n = 4'h0;
        ad = rd ? ~ad : wq[got];
      end
      pv = {cbe_n, ad};
      #1;
    end
  endtask
endmodule
`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench for the PCI target bus-phase front end
`timescale 1ns/10ps
`default_nettype none
`include "pci_phase_consts.vh"
module tb;
  logic clk_in = 0, rst_n_in = 0, hit_in = 0, idsel_in = 0, stall = 1;
  logic wdata_ready_in = 0, rdata_valid_in = 0;
  logic [31:0] rdata_in = 32'hA5A50000, lf = 32'h4C5F, v;
  wire logic pck, frm, irdy, par, po, poe, aoe, trdy, sel, ape, dpe, wv, rr;
  wire logic [31:0] ad, ado;
  wire logic [3:0] cbe;
  wire logic [35:0] wd;
  wire logic av, wro, cfgo;
  wire logic [31:0] ao;
  logic [33:0] claim_q = 34'h0;
  int error_cnt = 0, checks_done = 0, ri = 0, b;
  logic [35:0] exp_w [$];
  logic [3:0] rc [3] = '{`CMD_MEM_RD, `CMD_MEM_RD_MUL, `CMD_MEM_RD_LN};
  logic [3:0] uc [4] = '{4'h0, 4'h1, 4'h2, 4'h3};
  function automatic logic [31:0] nx(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Read word the bench offers for index k
  function automatic logic [31:0] rword(input int k);
    return 32'hA5A50000 + 32'(k) * 32'h01030107;
  endfunction
  task automatic chk(input logic [35:0] g, input logic [35:0] e);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [3:0] c, input int n, input bit bp);
    for (int i = 0; i < n; i++) begin
      v = nx(lf ^ 32'(i));
      m.wq[i] = v;
      exp_w.push_back({4'h0, v});
    end
    m.xfer(c, 32'h1000, n, 0, bp);
    repeat (300) @(posedge clk_in);
    chk(36'(claim_q), 36'({2'b01, 32'h1000}));
  endtask
  pci_master_model m (.pci_clk(pck), .frame_n(frm), .irdy_n(irdy), .par(par),
    .ad(ad), .cbe_n(cbe), .trdy_n(trdy), .devsel_n(sel), .par_oe_n(poe),
    .par_rd(po), .ad_rd(ado));
  pci_target_bus_phase_logic #(.DEPTH(32), .AW(5)) uut (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .pci_clk_in(pck), .frame_n_in(frm), .irdy_n_in(irdy),
    .ad_in(ad), .cbe_n_in(cbe), .par_in(par), .par_out(po), .par_oe_n_out(poe),
    .ad_oe_n_out(aoe), .ad_out(ado), .trdy_n_out(trdy), .devsel_n_out(sel),
    .hit_in(hit_in), .idsel_in(idsel_in), .addr_perr_out(ape),
    .data_perr_out(dpe), .is_write_out(wro), .is_cfg_out(cfgo),
    .addr_out(ao), .addr_valid_out(av), .final_phase_out(),
    .wait_state_out(),
    .wdata_out(wd), .wdata_valid_out(wv), .wdata_ready_in(wdata_ready_in),
    .rdata_in(rdata_in), .rdata_valid_in(rdata_valid_in),
    .rdata_ready_out(rr));
  initial forever #20 clk_in = ~clk_in;
  // Random stalls both sides; offered read word held until taken
  always @(posedge clk_in) begin
    lf <= nx(lf);
    wdata_ready_in <= !stall && lf[0];
    rdata_valid_in <= (rdata_valid_in && !rr) | lf[1];
    if (rr && rdata_valid_in) begin
      ri <= ri + 1;
      rdata_in <= rword(ri + 1);
    end
    // Last claimed command class, write flag and address
    if (av) claim_q <= {cfgo, wro, ao};
    if (wv && wdata_ready_in) chk(wd, exp_w.pop_front());
  end
  initial begin
    #(40 * 60000);
    error_cnt++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    hit_in <= 1'b1;
    fork
      wr(`CMD_MEM_WR, 36, 0);
      begin repeat (600) @(posedge clk_in); stall <= 1'b0; end
    join
    wr(`CMD_MEM_WR_INV, 5, 0);
    chk(36'(exp_w.size()), 0);
    chk(36'({ape, dpe}), 0);
    $display("write test done");
    foreach (rc[k]) begin
      b = ri;
      m.xfer(rc[k], 32'h2000, 3, 1, 0);
      for (int i = 0; i < 3; i++) chk(36'(m.rq[i]), 36'(rword(b + i)));
      chk(36'(claim_q), 36'({2'b00, 32'h2000}));
    end
    chk(36'(m.bad), 0);
    $display("read test done");
    idsel_in <= 1'b1;
    foreach (uc[k]) begin
      m.xfer(uc[k], 32'h3000, 1, 0, 0);
      chk(36'(m.seen), 0);
    end
    hit_in <= 1'b0;
    m.xfer(`CMD_CFG_RD, 32'h0, 1, 1, 0);
    chk(36'(m.seen), 1);
    chk(36'(claim_q), 36'({2'b10, 32'h0}));
    idsel_in <= 1'b0;
    m.xfer(`CMD_MEM_WR, 32'h4000, 1, 0, 0);
    chk(36'(m.seen), 0);
    $display("claim test done");
    hit_in <= 1'b1;
    wr(`CMD_MEM_WR, 1, 1);
    chk(36'(dpe), 1);
    $display("parity test done");
    conclude();
  end
endmodule
`default_nettype wire
